// ### rtl/prog_state_defines.svh
`ifndef PROG_STATE_DEFINES_SVH
`define PROG_STATE_DEFINES_SVH

// Register port offsets (byte addresses)
`define OFS_GPR_TOP 8'h3C
`define OFS_PSW 8'h40
`define OFS_PC 8'h44
`define OFS_SSP 8'h48
`define OFS_USP 8'h4C
`define OFS_RP 8'h50
`define OFS_MDH 8'h54
`define OFS_MDL 8'h58
`define OFS_RAMCTL 8'h5C
`define OFS_BRK 8'h60

// Status word field positions
`define PSW_C 0
`define PSW_V 1
`define PSW_Z 2
`define PSW_N 3
`define PSW_I 4
`define PSW_S 5
`define PSW_T 8
`define PSW_D0 9
`define PSW_D1 10
`define PSW_ILM_LO 16
`define PSW_ILM_HI 20
`define PSW_MASK 32'h001F073F

// Reset values
`define RST_SSP 32'h00000000
`define RST_ILM 5'h0F

// Timing counts in core cycles
`define IRQ_RSP_CYC 3'h6
`define MUL_LONG_CYC 3'h5
`define MUL_SHORT_CYC 3'h3

// Usable RAM window after reset, bytes
`define RAM_LIMIT 32'h00001000

`endif

// ### rtl/prog_state_pkg.sv
package prog_state_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b01,
    IRQ_SAVE = 2'b10
  } irq_st_e;

endpackage : prog_state_pkg

// ### rtl/prog_state_regs.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "prog_state_defines.svh"
module prog_state_regs
  import prog_state_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  // Software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Core register file port
  input wire logic [3:0] core_raddr,
  output logic [31:0] core_rdata,
  input wire logic core_we,
  input wire logic [3:0] core_waddr,
  input wire logic [31:0] core_wdata,
  // Flag and status updates
  input wire logic flag_we,
  input wire logic [3:0] flag_nzvc,
  input wire logic div_step,
  input wire logic [1:0] div_flags,
  input wire logic psw_op_we,
  input wire logic [31:0] psw_op_data,
  output logic [31:0] psw,
  // Program flow
  input wire logic pc_we,
  input wire logic [31:0] pc_next,
  input wire logic call_op,
  input wire logic ret_op,
  input wire logic instr_retire,
  output logic [31:0] ibus_addr,
  // Interrupts
  input wire logic irq_req,
  input wire logic [4:0] irq_level,
  input wire logic nmi_req,
  output logic irq_busy,
  output logic irq_ack,
  output logic [31:0] save_pc,
  output logic [31:0] save_psw,
  // Multiplier
  input wire logic mul_start,
  input wire logic mul_long,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  output logic mul_done,
  // Memory checks
  input wire logic ram_req,
  input wire logic [31:0] ram_offset,
  output logic ram_err,
  input wire logic fetch_dbus,
  output logic fetch_fault,
  input wire logic dacc_valid,
  input wire logic [31:0] dacc_addr,
  output logic hw_break
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0] gpr_ff [0:14];
  logic [31:0] ssp_ff;
  logic [31:0] usp_ff;
  logic [31:0] rp_ff;
  logic [31:0] pc_ff;
  logic [31:0] mdh_ff;
  logic [31:0] mdl_ff;
  logic s_ff;
  logic i_ff;
  logic [3:0] nzvc_ff;
  logic t_ff;
  logic [1:0] d_ff;
  logic [4:0] ilm_ff;
  logic ram_open_ff;
  logic [29:0] brk_word_ff;
  logic brk_en_ff;
  logic brk_pend_ff;
  logic [31:0] rdata_ff;
  logic [31:0] crdata_ff;
  logic ram_err_ff;
  logic fault_ff;
  irq_st_e irq_st_ff;
  logic [2:0] irq_cnt_ff;
  logic [4:0] irq_lvl_ff;
  logic irq_nmi_ff;
  logic [31:0] save_pc_ff;
  logic [31:0] save_psw_ff;
  logic [2:0] mul_cnt_ff;
  logic irq_take;
  logic sw_wr_gpr;
  logic [31:0] psw_rd;

  // Register fifteen follows the stack select flag
  function automatic logic [31:0] gpr_rd(input logic [3:0] idx);
    logic [31:0] v;
    v = 32'h00000000;
    if (idx == 4'hF) begin
      v = s_ff ? usp_ff : ssp_ff;
    end else begin
      v = gpr_ff[idx];
    end
    return v;
  endfunction : gpr_rd

  // Assembled status word, holes forced to zero
  always_comb begin
    psw_rd = 32'h00000000;
    psw_rd[`PSW_C] = nzvc_ff[0];
    psw_rd[`PSW_V] = nzvc_ff[1];
    psw_rd[`PSW_Z] = nzvc_ff[2];
    psw_rd[`PSW_N] = nzvc_ff[3];
    psw_rd[`PSW_I] = i_ff;
    psw_rd[`PSW_S] = s_ff;
    psw_rd[`PSW_T] = t_ff;
    psw_rd[`PSW_D0] = d_ff[0];
    psw_rd[`PSW_D1] = d_ff[1];
    psw_rd[`PSW_ILM_HI:`PSW_ILM_LO] = ilm_ff;
  end

  assign psw = psw_rd & `PSW_MASK;
  assign sw_wr_gpr = reg_wr && (reg_addr <= `OFS_GPR_TOP);

  // ------------------------------------------------------------
  // General registers
  // ------------------------------------------------------------
  // Zero to fourteen carry no reset: saves area, values undefined
  always_ff @(posedge clk) begin
    if (core_we && core_waddr != 4'hF) begin
      gpr_ff[core_waddr] <= core_wdata;
    end else if (sw_wr_gpr && reg_addr[5:2] != 4'hF) begin
      gpr_ff[reg_addr[5:2]] <= reg_wdata;
    end
  end

  // System stack pointer; interrupt save pushes two words
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ssp_ff <= `RST_SSP;
    end else if (irq_take) begin
      ssp_ff <= ssp_ff - 32'h00000008;
    end else if (core_we && core_waddr == 4'hF && !s_ff) begin
      ssp_ff <= core_wdata;
    end else if (reg_wr && reg_addr == `OFS_SSP) begin
      ssp_ff <= reg_wdata;
    end else if (sw_wr_gpr && reg_addr[5:2] == 4'hF && !s_ff) begin
      ssp_ff <= reg_wdata;
    end
  end

  // User stack pointer, no reset
  always_ff @(posedge clk) begin
    if (core_we && core_waddr == 4'hF && s_ff) begin
      usp_ff <= core_wdata;
    end else if (reg_wr && reg_addr == `OFS_USP) begin
      usp_ff <= reg_wdata;
    end else if (sw_wr_gpr && reg_addr[5:2] == 4'hF && s_ff) begin
      usp_ff <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  // Stack select, enable and level mask; ack sets the accepted level, 15 for NMI
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= 1'b0;
      i_ff <= 1'b0;
      ilm_ff <= `RST_ILM;
    end else if (irq_ack) begin
      s_ff <= 1'b0;
      ilm_ff <= irq_nmi_ff ? 5'h0F : irq_lvl_ff;
    end else if (psw_op_we) begin
      // Skipped when irq_ack falls in this cycle; the acknowledge wins
      s_ff <= psw_op_data[`PSW_S];
      i_ff <= psw_op_data[`PSW_I];
      ilm_ff <= psw_op_data[`PSW_ILM_HI:`PSW_ILM_LO];
    end else if (reg_wr && reg_addr == `OFS_PSW) begin
      s_ff <= reg_wdata[`PSW_S];
      i_ff <= reg_wdata[`PSW_I];
      ilm_ff <= reg_wdata[`PSW_ILM_HI:`PSW_ILM_LO];
    end
  end

  // Arithmetic flags and system bits are left unreset
  always_ff @(posedge clk) begin
    if (flag_we) begin
      nzvc_ff <= flag_nzvc;
    end else if (psw_op_we) begin
      nzvc_ff <= psw_op_data[3:0];
    end else if (reg_wr && reg_addr == `OFS_PSW) begin
      nzvc_ff <= reg_wdata[3:0];
    end
  end

  // Divide flags update ahead of any exception in the same cycle
  always_ff @(posedge clk) begin
    if (div_step) begin
      d_ff <= div_flags;
    end else if (psw_op_we) begin
      d_ff <= psw_op_data[`PSW_D1:`PSW_D0];
      t_ff <= psw_op_data[`PSW_T];
    end else if (reg_wr && reg_addr == `OFS_PSW) begin
      d_ff <= reg_wdata[`PSW_D1:`PSW_D0];
      t_ff <= reg_wdata[`PSW_T];
    end
  end

  // ------------------------------------------------------------
  // Program counter and return pointer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ret_op) begin
      pc_ff <= rp_ff;
    end else if (pc_we || call_op) begin
      pc_ff <= pc_next;
    end
  end

  always_ff @(posedge clk) begin
    if (call_op) begin
      rp_ff <= pc_ff;
    end else if (reg_wr && reg_addr == `OFS_RP) begin
      rp_ff <= reg_wdata;
    end
  end

  // Fetch address comes only from the counter, never the data side
  assign ibus_addr = pc_ff;

  // ------------------------------------------------------------
  // Interrupt response
  // ------------------------------------------------------------
  assign irq_busy = (irq_st_ff == IRQ_SAVE);
  assign irq_take = !irq_busy && (nmi_req ||
    (irq_req && i_ff && irq_level < ilm_ff));
  assign irq_ack = irq_busy && irq_cnt_ff == 3'h1;

  // Snapshot at acceptance; nesting allowed once the ack is out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_st_ff <= IRQ_IDLE;
      irq_cnt_ff <= 3'h0;
      irq_lvl_ff <= 5'h00;
      irq_nmi_ff <= 1'b0;
      save_pc_ff <= 32'h00000000;
      save_psw_ff <= 32'h00000000;
    end else begin
      case (irq_st_ff)
        IRQ_IDLE: begin
          if (irq_take) begin
            irq_st_ff <= IRQ_SAVE;
            irq_cnt_ff <= `IRQ_RSP_CYC;
            irq_lvl_ff <= irq_level;
            irq_nmi_ff <= nmi_req;
            save_pc_ff <= pc_ff;
            save_psw_ff <= psw;
          end
        end
        IRQ_SAVE: begin
          irq_cnt_ff <= irq_cnt_ff - 3'h1;
          if (irq_ack) begin
            irq_st_ff <= IRQ_IDLE;
          end
        end
        default: begin
          irq_st_ff <= IRQ_IDLE;
        end
      endcase
    end
  end

  assign save_pc = save_pc_ff;
  assign save_psw = save_psw_ff;

  // ------------------------------------------------------------
  // Multiplier
  // ------------------------------------------------------------
  // Product taken at start; done is only a timing mark
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mul_cnt_ff <= 3'h0;
    end else if (mul_cnt_ff != 3'h0) begin
      mul_cnt_ff <= mul_cnt_ff - 3'h1;
    end else if (mul_start) begin
      mul_cnt_ff <= mul_long ? `MUL_LONG_CYC : `MUL_SHORT_CYC;
    end
  end

  always_ff @(posedge clk) begin
    if (mul_start && mul_cnt_ff == 3'h0) begin
      if (mul_long) begin
        {mdh_ff, mdl_ff} <= $signed(mul_a) * $signed(mul_b);
      end else begin
        mdh_ff <= 32'h00000000;
        mdl_ff <= $signed(mul_a[15:0]) * $signed(mul_b[15:0]);
      end
    end
  end

  assign mul_done = (mul_cnt_ff == 3'h1);

  // ------------------------------------------------------------
  // Memory checks and break
  // ------------------------------------------------------------
  // Window stays closed until software opens it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ram_open_ff <= 1'b0;
      ram_err_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_RAMCTL) begin
        ram_open_ff <= reg_wdata[0];
      end
      ram_err_ff <= ram_req && !ram_open_ff &&
        ram_offset >= `RAM_LIMIT;
      fault_ff <= fetch_dbus;
    end
  end

  assign ram_err = ram_err_ff;
  assign fetch_fault = fault_ff;

  // Stack area hit arms a break, fired at next retirement
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      brk_word_ff <= 30'h00000000;
      brk_en_ff <= 1'b0;
      brk_pend_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_BRK) begin
        brk_word_ff <= reg_wdata[31:2];
        brk_en_ff <= reg_wdata[0];
      end
      if (brk_en_ff && dacc_valid && dacc_addr[31:2] == brk_word_ff &&
          brk_word_ff == ssp_ff[31:2]) begin
        brk_pend_ff <= 1'b1;
      end else if (instr_retire) begin
        brk_pend_ff <= 1'b0;
      end
    end
  end

  assign hw_break = brk_pend_ff && instr_retire;

  // ------------------------------------------------------------
  // Read ports
  // ------------------------------------------------------------
  // Data stands one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b || !reg_rd) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_addr <= `OFS_GPR_TOP) begin
      rdata_ff <= gpr_rd(reg_addr[5:2]);
    end else begin
      case (reg_addr)
        `OFS_PSW: rdata_ff <= psw;
        `OFS_PC: rdata_ff <= pc_ff;
        `OFS_SSP: rdata_ff <= ssp_ff;
        `OFS_USP: rdata_ff <= usp_ff;
        `OFS_RP: rdata_ff <= rp_ff;
        `OFS_MDH: rdata_ff <= mdh_ff;
        `OFS_MDL: rdata_ff <= mdl_ff;
        `OFS_RAMCTL: rdata_ff <= {31'h00000000, ram_open_ff};
        `OFS_BRK: rdata_ff <= {brk_word_ff, 1'b0, brk_en_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    crdata_ff <= gpr_rd(core_raddr);
  end

  assign reg_rdata = rdata_ff;
  assign core_rdata = crdata_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_sp_reset: assert property ($rose(rst_b) |-> ssp_ff == 32'h0)
    else $error("stack pointer not zero after reset");
  chk_flags_reset: assert property ($rose(rst_b) |-> !s_ff && !i_ff)
    else $error("stack select or enable set after reset");
  chk_ilm_reset: assert property ($rose(rst_b) |-> ilm_ff == 5'd15)
    else $error("level mask not fifteen after reset");
  chk_psw_holes: assert property ((psw & ~32'h001F073F) == 32'h0)
    else $error("reserved status bit reads one");
  chk_irq_gate: assert property (irq_req && !nmi_req && !irq_busy &&
    (!i_ff || irq_level >= ilm_ff) |=> !irq_busy)
    else $error("maskable interrupt taken while blocked");
  chk_irq_six: assert property (irq_take |-> ##6 irq_ack)
    else $error("interrupt response not six cycles");
  chk_mul_long: assert property (mul_start && mul_long && mul_cnt_ff == 3'h0
    |-> !mul_done [*5] ##1 mul_done)
    else $error("long multiply not five cycles");
  chk_mul_short: assert property (mul_start && !mul_long && mul_cnt_ff == 3'h0
    |-> ##3 mul_done)
    else $error("short multiply not three cycles");
  chk_div_early: assert property (div_step |=> d_ff == $past(div_flags))
    else $error("divide flags not updated");
  chk_ram_window: assert property (ram_req && !ram_open_ff &&
    ram_offset >= 32'h1000 |=> ram_err)
    else $error("access beyond four kilobytes not flagged");
  chk_call_save: assert property (call_op && !ret_op |=>
    rp_ff == $past(pc_ff) && pc_ff == $past(pc_next))
    else $error("call did not save counter");
  chk_sp_break: assert property (brk_pend_ff && instr_retire |-> hw_break
    ##1 (!brk_pend_ff || $past(dacc_valid)))
    else $error("stack break not raised after instruction");

endmodule : prog_state_regs

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import prog_state_pkg::*;
;
  logic clk, rst_b;
  logic [7:0] reg_addr;
  word_t reg_wdata, reg_rdata, core_rdata, core_wdata, psw_op_data, psw, pc_next;
  word_t ibus_addr, save_pc, save_psw, mul_a, mul_b, ram_offset, dacc_addr;
  logic reg_wr, reg_rd, core_we, flag_we, div_step, psw_op_we, pc_we, call_op, ret_op;
  logic [3:0] core_raddr, core_waddr, flag_nzvc;
  logic [1:0] div_flags;
  logic instr_retire, irq_req, nmi_req, irq_busy, irq_ack, mul_start, mul_long, mul_done;
  logic [4:0] irq_level;
  logic ram_req, ram_err, fetch_dbus, fetch_fault, dacc_valid, hw_break;
  int num_errors, num_checks, n;

  prog_state_regs DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_raddr(core_raddr),
    .core_rdata(core_rdata), .core_we(core_we), .core_waddr(core_waddr),
    .core_wdata(core_wdata), .flag_we(flag_we), .flag_nzvc(flag_nzvc), .div_step(div_step),
    .div_flags(div_flags), .psw_op_we(psw_op_we), .psw_op_data(psw_op_data), .psw(psw),
    .pc_we(pc_we), .pc_next(pc_next), .call_op(call_op), .ret_op(ret_op),
    .instr_retire(instr_retire), .ibus_addr(ibus_addr), .irq_req(irq_req),
    .irq_level(irq_level), .nmi_req(nmi_req), .irq_busy(irq_busy), .irq_ack(irq_ack),
    .save_pc(save_pc), .save_psw(save_psw), .mul_start(mul_start), .mul_long(mul_long),
    .mul_a(mul_a), .mul_b(mul_b), .mul_done(mul_done), .ram_req(ram_req),
    .ram_offset(ram_offset), .ram_err(ram_err), .fetch_dbus(fetch_dbus),
    .fetch_fault(fetch_fault), .dacc_valid(dacc_valid), .dacc_addr(dacc_addr),
    .hw_break(hw_break));

  // ---------------------------------------------------------------
  // Clock and helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare, count, report
  task chk(input word_t got, input word_t exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One edge; every one-cycle strobe but reg_wr and reg_rd drops after it, so pulses last one cycle
  task tick;
    @(posedge clk);
    {core_we, flag_we, div_step, psw_op_we, pc_we, call_op, ret_op} <= '0;
    {instr_retire, ram_req, fetch_dbus, dacc_valid, irq_req, nmi_req, mul_start} <= '0;
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input word_t exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Edges from request raise until the completion pulse, bounded
  task count_to(input logic use_mul);
    n = 0;
    while (n < 20) begin
      tick;
      n++;
      if ((use_mul ? mul_done : irq_ack) === 1'b1) break;
    end
  endtask : count_to

  task conclude;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    conclude;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, core_we, flag_we, div_step, psw_op_we, pc_we} = '0;
    {call_op, ret_op, instr_retire, irq_req, nmi_req, mul_start, mul_long} = '0;
    {ram_req, fetch_dbus, dacc_valid} = '0;
    {reg_addr, reg_wdata, core_raddr, core_waddr, core_wdata, flag_nzvc} = '0;
    {div_flags, psw_op_data, pc_next, irq_level, mul_a, mul_b, ram_offset, dacc_addr} = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state of status and stack pointer
    #1;
    chk({26'h0, psw[5:4]}, 32'h0);
    chk({27'h0, psw[20:16]}, 32'h0000000F);
    chk(psw & ~32'h001F073F, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'h3C, 32'h0);
    rd(8'h80, 32'h0);
    // Holes read zero whatever was written
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h001F073F);
    // Stack select set: index fifteen lands in the user pointer
    @(posedge clk);
    core_we <= 1'b1;
    core_waddr <= 4'hF;
    core_wdata <= 32'h12345678;
    core_raddr <= 4'hF;
    tick;
    rd(8'h4C, 32'h12345678);
    rd(8'h48, 32'h0);
    chk(core_rdata, 32'h12345678);
    wr(8'h40, 32'h0);
    // Flag, divide and status-op updates
    @(posedge clk);
    flag_we <= 1'b1;
    flag_nzvc <= 4'hA;
    tick;
    chk(psw, 32'h0000000A);
    @(posedge clk);
    div_step <= 1'b1;
    div_flags <= 2'b11;
    tick;
    chk(psw, 32'h0000060A);
    @(posedge clk);
    psw_op_we <= 1'b1;
    psw_op_data <= 32'hFFEE00F0;
    tick;
    chk(psw, 32'h000E0030);
    wr(8'h40, 32'h000E0010);
    // Level 13 below mask 14 is taken; divide flags land before it
    @(posedge clk);
    irq_req <= 1'b1;
    irq_level <= 5'd13;
    div_step <= 1'b1;
    div_flags <= 2'b01;
    count_to(1'b0);
    chk(n, 6);
    // Level mask and stack select change at the acknowledge edge
    tick;
    chk(psw, 32'h000D0210);
    rd(8'h48, 32'hFFFFFFF8);
    // Equal level is refused
    @(posedge clk);
    irq_req <= 1'b1;
    tick;
    tick;
    chk({31'h0, irq_busy}, 32'h0);
    // Non-maskable ignores the mask
    @(posedge clk);
    nmi_req <= 1'b1;
    count_to(1'b0);
    chk(n, 6);
    tick;
    chk({27'h0, psw[20:16]}, 32'h0000000F);
    // Counter: read-only, call and return
    @(posedge clk);
    pc_we <= 1'b1;
    pc_next <= 32'h00000100;
    tick;
    chk(ibus_addr, 32'h00000100);
    wr(8'h44, 32'h0000DEAD);
    rd(8'h44, 32'h00000100);
    @(posedge clk);
    call_op <= 1'b1;
    pc_next <= 32'h00000200;
    tick;
    chk(ibus_addr, 32'h00000200);
    rd(8'h50, 32'h00000100);
    @(posedge clk);
    ret_op <= 1'b1;
    tick;
    chk(ibus_addr, 32'h00000100);
    // Multiplier latency and results, long then short
    @(posedge clk);
    mul_start <= 1'b1;
    mul_long <= 1'b1;
    mul_a <= 32'hFFFFFFFE;
    mul_b <= 32'h00000003;
    count_to(1'b1);
    chk(n, 5);
    rd(8'h54, 32'hFFFFFFFF);
    rd(8'h58, 32'hFFFFFFFA);
    @(posedge clk);
    mul_start <= 1'b1;
    mul_long <= 1'b0;
    mul_a <= 32'h00000003;
    mul_b <= 32'h00000005;
    count_to(1'b1);
    chk(n, 3);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0000000F);
    // RAM window edge, then data-bus fetch
    @(posedge clk);
    ram_req <= 1'b1;
    ram_offset <= 32'h00000FFF;
    tick;
    chk({31'h0, ram_err}, 32'h0);
    ram_req <= 1'b1;
    ram_offset <= 32'h00001000;
    tick;
    chk({31'h0, ram_err}, 32'h1);
    fetch_dbus <= 1'b1;
    tick;
    chk({31'h0, fetch_fault}, 32'h1);
    // Standby-style sequence: write, read back twice, five idle cycles
    wr(8'h5C, 32'h00000001);
    rd(8'h5C, 32'h00000001);
    rd(8'h5C, 32'h00000001);
    repeat (5) tick;
    // Break on the system stack word after one instruction
    wr(8'h60, 32'hFFFFFFF1);
    tick;
    @(posedge clk);
    instr_retire <= 1'b1;
    #1;
    chk({31'h0, hw_break}, 32'h0);
    tick;
    dacc_valid <= 1'b1;
    dacc_addr <= 32'hFFFFFFF0;
    tick;
    instr_retire <= 1'b1;
    #1;
    chk({31'h0, hw_break}, 32'h1);
    tick;
    conclude;
  end
endmodule : tb_top
